// *** pkg/amsc_pkg.sv ***
// Constants, types and register map of the auxiliary measurement scheduler.
// Assumes one 20 MHz clock and the 8-bit special-function-register port of the core.
package amsc_pkg;

    // Register addresses on the special-function-register port
    localparam logic [7:0] ADDR_TEMP_RESULT = 8'hD7;
    localparam logic [7:0] ADDR_START_MEAS = 8'hD8;
    localparam logic [7:0] ADDR_BATT_RESULT = 8'hDF;
    localparam logic [7:0] ADDR_SUPPLY_RESULT = 8'hEF;
    localparam logic [7:0] ADDR_DELTA_CFG = 8'hF3;
    localparam logic [7:0] ADDR_PERIOD_CFG = 8'hF9;
    localparam logic [7:0] ADDR_BATT_THRESH = 8'hFA;

    // Reset values of the writable registers
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Field positions
    localparam int PLL_ACK_BIT = 7;
    localparam int SUPPLY_SEL_LSB = 4;
    localparam int BATT_SEL_LSB = 2;
    localparam int TEMP_SEL_LSB = 0;
    localparam int THERM_THR_LSB = 3;
    localparam int SUPPLY_THR_LSB = 0;

    // Channel codes double as bit positions in the start-measurement register
    localparam logic [1:0] CH_BATT = 2'h0;
    localparam logic [1:0] CH_TEMP = 2'h1;
    localparam logic [1:0] CH_SUPPLY = 2'h2;

    // Background intervals in minute ticks, for selector codes 01, 10, 11
    localparam int SUPPLY_MIN_01 = 8;
    localparam int SUPPLY_MIN_10 = 2;
    localparam int BATT_MIN_01 = 16;
    localparam int BATT_MIN_10 = 4;
    localparam int TEMP_MIN_01 = 8;
    localparam int TEMP_MIN_10 = 2;
    localparam int ANY_MIN_11 = 1;

    // Change-threshold codes that interrupt on every conversion (111) and never (000)
    localparam logic [2:0] THR_EVERY = 3'h7;
    localparam logic [2:0] THR_NONE = 3'h0;

    // Converter request sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ = 3'b010,
        ST_WAIT = 3'b100
    } amsc_state_t;

    // One register-port access from the core
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amsc_sfr_t;

    // One finished conversion from the converter
    typedef struct packed {
        logic done;
        logic [1:0] chan;
        logic [7:0] data;
    } amsc_result_t;

endpackage

// *** verilog/amsc_interval.sv ***
// Background interval timer for one measurement channel.
// Assumes a one-cycle minute tick synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module amsc_interval #(
    parameter int MIN_01 = 8,
    parameter int MIN_10 = 2,
    parameter int MIN_11 = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic minute_tick,
    input wire logic run_en,
    input wire logic [1:0] sel,
    input wire logic restart,
    // Event
    output logic strobe
);
    logic [4:0] cnt_reg;
    logic [4:0] period;

    // Interval length for the selected code
    always_comb begin
        case (sel)
            2'h1: period = 5'(MIN_01);
            2'h2: period = 5'(MIN_10);
            2'h3: period = 5'(MIN_11);
            default: period = 5'h00;
        endcase
    end

    // Count minutes; a rewrite of the selector starts a fresh interval
    always_ff @(posedge ref_clk) begin
        if (!rst_n || restart) begin
            cnt_reg <= 5'h00;
            strobe <= 1'b0;
        end else if (run_en && sel != 2'h0 && minute_tick) begin
            if (cnt_reg + 5'h01 >= period) begin
                cnt_reg <= 5'h00;
                strobe <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
                strobe <= 1'b0;
            end
        end else begin
            strobe <= 1'b0;
        end
    end

    a_halt_without_clock:
        assert property (@(posedge ref_clk) disable iff (!rst_n) !run_en |=> !strobe)
        else $error("background strobe while calendar clock disabled");
    a_restart_clears:
        assert property (@(posedge ref_clk) disable iff (!rst_n) restart |=> cnt_reg == 5'h00 && !strobe)
        else $error("interval counter not restarted");
    a_disabled_sel:
        assert property (@(posedge ref_clk) disable iff (!rst_n) sel == 2'h0 |=> !strobe)
        else $error("strobe with interval code 00");
endmodule // amsc_interval
`default_nettype wire

// *** verilog/amsc_delta.sv ***
// Change detector: does a new reading differ from the reference by more than a code?
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ns
`default_nettype none
module amsc_delta (
    // Values
    input wire logic [7:0] new_val,
    input wire logic [7:0] ref_val,
    input wire logic [2:0] code,
    // Verdict
    output logic hit
);
    logic [7:0] diff;

    // Absolute difference against threshold; 000 never, 111 always
    always_comb begin
        diff = (new_val >= ref_val) ? new_val - ref_val : ref_val - new_val;
        if (code == amsc_pkg::THR_NONE) begin
            hit = 1'b0;
        end else if (code == amsc_pkg::THR_EVERY) begin
            hit = 1'b1;
        end else begin
            hit = diff > {5'h00, code};
        end
    end
endmodule // amsc_delta
`default_nettype wire

// *** verilog/amsc_scheduler.sv ***
// Auxiliary measurement scheduler: registers, request sequencer and result handling.
// Assumes the core port, converter handshake and minute tick are synchronous to ref_clk.
//
// Functional notes
// - Supply interval codes: off, 8, 2, 1 minutes
// - Battery interval codes: off, 16, 4, 1 minutes
// - Temperature interval codes: off, 8, 2, 1 minutes
// - Background strobes only while calendar clock enabled
// - Temperature change threshold; 111 means every conversion
// - Supply change threshold; 111 means every conversion
// - Writing bit 7 clears PLL fault
// - Lock-loss reset sets PLL fault until acknowledged
// - Bit 2 requests supply conversion, self-clears
// - Bit 1 requests temperature conversion, self-clears
// - Bit 0 requests battery conversion, self-clears
// - Battery below threshold raises interrupt
// - Measurements may keep running in low-power states
// - Result registers load only on interrupt
// - Interrupt when change exceeds delta from reference
// - Low battery sets power monitor flag
`timescale 1ns/1ns
`default_nettype none
module amsc_scheduler (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Core register port
    input wire amsc_pkg::amsc_sfr_t sfr,
    output logic [7:0] sfr_rdata,
    // Calendar clock side
    input wire logic clock_calendar_enable,
    input wire logic minute_tick,
    // Power state and low-power keep-alive per channel (bit = channel code)
    input wire logic battery_power_state,
    input wire logic sleep_power_state,
    input wire logic [2:0] lowpower_keep,
    // Reset cause and flag clearing
    input wire logic lock_loss_cause,
    input wire logic low_battery_clear,
    // Converter handshake
    output logic conv_req,
    output logic [1:0] conv_chan,
    input wire logic conv_ack,
    input wire amsc_pkg::amsc_result_t conv_res,
    // Events and flags
    output logic adc_irq,
    output logic low_battery_flag,
    output logic lock_loss_fault
);
    amsc_pkg::amsc_state_t state_reg;
    logic [7:0] temperature_result, battery_result, supply_input_result;
    logic [7:0] change_delta_config, background_period_config, battery_low_threshold;
    logic [2:0] go_reg;
    logic [2:0] bg_pend_reg;
    logic [7:0] temp_last_reg, supply_last_reg;
    logic cur_single_reg;
    logic [2:0] strobe;
    logic period_wr, go_wr, full_power;
    logic temp_hit, supply_hit;
    logic [1:0] pick_chan;
    logic pick_single, pick_any;
    logic res_temp, res_batt, res_supply, batt_low;
    logic irq_temp, irq_batt, irq_supply;

    assign go_wr = sfr.we && sfr.addr == amsc_pkg::ADDR_START_MEAS;
    assign period_wr = sfr.we && sfr.addr == amsc_pkg::ADDR_PERIOD_CFG;
    assign full_power = !battery_power_state && !sleep_power_state;

    // One interval timer per channel, indexed by channel code
    amsc_interval #(.MIN_01(amsc_pkg::BATT_MIN_01), .MIN_10(amsc_pkg::BATT_MIN_10),
        .MIN_11(amsc_pkg::ANY_MIN_11)) u_batt_int (
        .ref_clk(ref_clk), .rst_n(rst_n), .minute_tick(minute_tick), .run_en(clock_calendar_enable),
        .sel(background_period_config[amsc_pkg::BATT_SEL_LSB +: 2]), .restart(period_wr),
        .strobe(strobe[0]));
    amsc_interval #(.MIN_01(amsc_pkg::TEMP_MIN_01), .MIN_10(amsc_pkg::TEMP_MIN_10),
        .MIN_11(amsc_pkg::ANY_MIN_11)) u_temp_int (
        .ref_clk(ref_clk), .rst_n(rst_n), .minute_tick(minute_tick), .run_en(clock_calendar_enable),
        .sel(background_period_config[amsc_pkg::TEMP_SEL_LSB +: 2]), .restart(period_wr),
        .strobe(strobe[1]));
    amsc_interval #(.MIN_01(amsc_pkg::SUPPLY_MIN_01), .MIN_10(amsc_pkg::SUPPLY_MIN_10),
        .MIN_11(amsc_pkg::ANY_MIN_11)) u_supply_int (
        .ref_clk(ref_clk), .rst_n(rst_n), .minute_tick(minute_tick), .run_en(clock_calendar_enable),
        .sel(background_period_config[amsc_pkg::SUPPLY_SEL_LSB +: 2]), .restart(period_wr),
        .strobe(strobe[2]));

    // Change detectors against the last interrupting value
    amsc_delta u_temp_delta (
        .new_val(conv_res.data), .ref_val(temp_last_reg),
        .code(change_delta_config[amsc_pkg::THERM_THR_LSB +: 3]), .hit(temp_hit));
    amsc_delta u_supply_delta (
        .new_val(conv_res.data), .ref_val(supply_last_reg),
        .code(change_delta_config[amsc_pkg::SUPPLY_THR_LSB +: 3]), .hit(supply_hit));

    // Configuration registers; bits 7:6 of the period register are stored as written,
    // so software must keep them clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            change_delta_config <= amsc_pkg::RST_BYTE;
            background_period_config <= amsc_pkg::RST_BYTE;
            battery_low_threshold <= amsc_pkg::RST_BYTE;
        end else if (sfr.we) begin
            if (sfr.addr == amsc_pkg::ADDR_DELTA_CFG) begin
                change_delta_config <= sfr.wdata;
            end else if (sfr.addr == amsc_pkg::ADDR_PERIOD_CFG) begin
                background_period_config <= sfr.wdata;
            end else if (sfr.addr == amsc_pkg::ADDR_BATT_THRESH) begin
                battery_low_threshold <= sfr.wdata;
            end
        end
    end

    // Priority pick: single requests before background, supply, temperature, battery
    always_comb begin
        pick_single = |go_reg;
        pick_any = pick_single || |bg_pend_reg;
        if (pick_single ? go_reg[2] : bg_pend_reg[2]) begin
            pick_chan = amsc_pkg::CH_SUPPLY;
        end else if (pick_single ? go_reg[1] : bg_pend_reg[1]) begin
            pick_chan = amsc_pkg::CH_TEMP;
        end else begin
            pick_chan = amsc_pkg::CH_BATT;
        end
    end

    // Request sequencer: one conversion in flight at a time
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= amsc_pkg::ST_IDLE;
            conv_req <= 1'b0;
            conv_chan <= amsc_pkg::CH_BATT;
            cur_single_reg <= 1'b0;
        end else begin
            case (state_reg)
                amsc_pkg::ST_IDLE: begin
                    if (pick_any) begin
                        state_reg <= amsc_pkg::ST_REQ;
                        conv_req <= 1'b1;
                        conv_chan <= pick_chan;
                        cur_single_reg <= pick_single;
                    end
                end
                amsc_pkg::ST_REQ: begin
                    if (conv_ack) begin
                        state_reg <= amsc_pkg::ST_WAIT;
                        conv_req <= 1'b0;
                    end
                end
                amsc_pkg::ST_WAIT: begin
                    if (conv_res.done) begin
                        state_reg <= amsc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= amsc_pkg::ST_IDLE;
                    conv_req <= 1'b0;
                end
            endcase
        end
    end

    // Start bits: cleared on acceptance, a write in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            go_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (go_wr && sfr.wdata[i]) begin
                    go_reg[i] <= 1'b1;
                end else if (state_reg == amsc_pkg::ST_REQ && conv_ack && cur_single_reg
                             && conv_chan == 2'(i)) begin
                    go_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Background pending bits; in low-power states only channels kept alive run
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bg_pend_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (strobe[i] && (full_power || lowpower_keep[i])) begin
                    bg_pend_reg[i] <= 1'b1;
                end else if (state_reg == amsc_pkg::ST_REQ && conv_ack && !cur_single_reg
                             && conv_chan == 2'(i)) begin
                    bg_pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt decisions for a finished conversion
    always_comb begin
        res_temp = conv_res.done && state_reg == amsc_pkg::ST_WAIT && conv_res.chan == amsc_pkg::CH_TEMP;
        res_batt = conv_res.done && state_reg == amsc_pkg::ST_WAIT && conv_res.chan == amsc_pkg::CH_BATT;
        res_supply = conv_res.done && state_reg == amsc_pkg::ST_WAIT
                     && conv_res.chan == amsc_pkg::CH_SUPPLY;
        batt_low = conv_res.data < battery_low_threshold;
        irq_temp = res_temp && (cur_single_reg || temp_hit);
        irq_supply = res_supply && (cur_single_reg || supply_hit);
        irq_batt = res_batt && (cur_single_reg || batt_low);
    end

    // Result registers take a converter value only with an interrupt; hardware beats software
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            temperature_result <= amsc_pkg::RST_BYTE;
            battery_result <= amsc_pkg::RST_BYTE;
            supply_input_result <= amsc_pkg::RST_BYTE;
            temp_last_reg <= amsc_pkg::RST_BYTE;
            supply_last_reg <= amsc_pkg::RST_BYTE;
        end else begin
            if (irq_temp) begin
                temperature_result <= conv_res.data;
                temp_last_reg <= conv_res.data;
            end else if (sfr.we && sfr.addr == amsc_pkg::ADDR_TEMP_RESULT) begin
                temperature_result <= sfr.wdata;
            end
            if (irq_batt) begin
                battery_result <= conv_res.data;
            end else if (sfr.we && sfr.addr == amsc_pkg::ADDR_BATT_RESULT) begin
                battery_result <= sfr.wdata;
            end
            if (irq_supply) begin
                supply_input_result <= conv_res.data;
                supply_last_reg <= conv_res.data;
            end else if (sfr.we && sfr.addr == amsc_pkg::ADDR_SUPPLY_RESULT) begin
                supply_input_result <= sfr.wdata;
            end
        end
    end

    // Converter interrupt: one-cycle pulse after the result lands
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_irq <= 1'b0;
        end else begin
            adc_irq <= irq_temp || irq_batt || irq_supply;
        end
    end

    // Low battery flag: sticky, a new low reading wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            low_battery_flag <= 1'b0;
        end else if (res_batt && batt_low) begin
            low_battery_flag <= 1'b1;
        end else if (low_battery_clear) begin
            low_battery_flag <= 1'b0;
        end
    end

    // PLL fault: cause is sampled as a level after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lock_loss_fault <= 1'b0;
        end else if (lock_loss_cause) begin
            lock_loss_fault <= 1'b1;
        end else if (go_wr && sfr.wdata[amsc_pkg::PLL_ACK_BIT]) begin
            lock_loss_fault <= 1'b0;
        end
    end

    // Registered read data; unmapped addresses read zero, acknowledge bit reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.addr == amsc_pkg::ADDR_TEMP_RESULT) begin
            sfr_rdata <= temperature_result;
        end else if (sfr.addr == amsc_pkg::ADDR_START_MEAS) begin
            sfr_rdata <= {5'h00, go_reg};
        end else if (sfr.addr == amsc_pkg::ADDR_BATT_RESULT) begin
            sfr_rdata <= battery_result;
        end else if (sfr.addr == amsc_pkg::ADDR_SUPPLY_RESULT) begin
            sfr_rdata <= supply_input_result;
        end else if (sfr.addr == amsc_pkg::ADDR_DELTA_CFG) begin
            sfr_rdata <= change_delta_config;
        end else if (sfr.addr == amsc_pkg::ADDR_PERIOD_CFG) begin
            sfr_rdata <= background_period_config;
        end else if (sfr.addr == amsc_pkg::ADDR_BATT_THRESH) begin
            sfr_rdata <= battery_low_threshold;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_req_held:
        assert property (conv_req && !conv_ack |=> conv_req && $stable(conv_chan))
        else $error("request dropped before acceptance");
    a_one_in_flight:
        assert property (state_reg == amsc_pkg::ST_WAIT |-> !conv_req)
        else $error("second request while conversion in flight");
    a_go_self_clear:
        assert property (conv_req && conv_ack && cur_single_reg && !go_wr |=> !go_reg[$past(conv_chan)])
        else $error("start bit not cleared on acceptance");
    a_pll_ack_clears:
        assert property (go_wr && sfr.wdata[7] && !lock_loss_cause |=> !lock_loss_fault)
        else $error("fault not cleared by acknowledge");
    a_pll_fault_sets:
        assert property (lock_loss_cause |=> lock_loss_fault [*2] or (lock_loss_fault ##1 1'b1))
        else $error("lock loss not recorded");
    a_batt_low_flag:
        assert property (res_batt && batt_low |=> low_battery_flag && adc_irq && battery_result == $past(conv_res.data))
        else $error("low battery not flagged");
    a_result_hold:
        assert property (!res_temp && !(sfr.we && sfr.addr == amsc_pkg::ADDR_TEMP_RESULT) |=> $stable(temperature_result))
        else $error("temperature result changed without interrupt");
    a_every_temp:
        assert property (res_temp && change_delta_config[5:3] == 3'h7 |=> adc_irq ##1 !adc_irq)
        else $error("every-conversion threshold did not interrupt");
    a_no_supply_irq:
        assert property (res_supply && !cur_single_reg && change_delta_config[2:0] == 3'h0 |=> $stable(supply_input_result))
        else $error("supply result loaded with threshold 000");
endmodule // amsc_scheduler
`default_nettype wire

// *** verification/amsc_scheduler_tb.sv ***
// Self-checking testbench for the auxiliary measurement scheduler.
// Assumes the scheduler package is compiled first; the bench stands in for core, converter and calendar clock.
`timescale 1ns/1ns
`default_nettype none
module amsc_scheduler_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    amsc_pkg::amsc_sfr_t sfr = '0;
    amsc_pkg::amsc_result_t conv_res = '0;
    logic [7:0] sfr_rdata;
    logic clock_calendar_enable = 1'b0;
    logic minute_tick = 1'b0;
    logic battery_power_state = 1'b0;
    logic sleep_power_state = 1'b0;
    logic [2:0] lowpower_keep = 3'h0;
    logic lock_loss_cause = 1'b0;
    logic low_battery_clear = 1'b0;
    logic conv_req, conv_ack = 1'b0, adc_irq, low_battery_flag, lock_loss_fault;
    logic [1:0] conv_chan;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    amsc_scheduler dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .clock_calendar_enable(clock_calendar_enable), .minute_tick(minute_tick),
        .battery_power_state(battery_power_state), .sleep_power_state(sleep_power_state),
        .lowpower_keep(lowpower_keep), .lock_loss_cause(lock_loss_cause),
        .low_battery_clear(low_battery_clear), .conv_req(conv_req), .conv_chan(conv_chan),
        .conv_ack(conv_ack), .conv_res(conv_res), .adc_irq(adc_irq),
        .low_battery_flag(low_battery_flag), .lock_loss_fault(lock_loss_fault));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    task automatic give_verdict;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, generous against the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write is taken at the edge that lowers the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) sfr <= '{1'b1, a, d};
        @(posedge ref_clk) sfr.we <= 1'b0;
    endtask

    // Read data is registered, so look two edges after the address settles
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk) sfr.addr <= a;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        chk(sfr_rdata, e);
    endtask

    task automatic tick;
        @(posedge ref_clk) minute_tick <= 1'b1;
        @(posedge ref_clk) minute_tick <= 1'b0;
    endtask

    // Converter side: accept the request, return a result, count interrupt cycles
    task automatic conv(input logic [1:0] ch, input logic [7:0] d, input logic [7:0] irq);
        int n;
        logic [7:0] hits;
        n = 0;
        hits = 8'h00;
        #1;
        while (conv_req !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({7'h00, conv_req}, 8'h01);
        chk({6'h00, conv_chan}, {6'h00, ch});
        @(posedge ref_clk) conv_ack <= 1'b1;
        @(posedge ref_clk) conv_ack <= 1'b0;
        conv_res <= '{1'b1, ch, d};
        @(posedge ref_clk) conv_res.done <= 1'b0;
        repeat (3) begin
            #1;
            hits = hits + {7'h00, adc_irq};
            @(posedge ref_clk);
        end
        chk(hits, irq);
    endtask

    // A request must not appear within the given number of cycles
    task automatic no_req(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            #1;
            seen = seen | conv_req;
            @(posedge ref_clk);
        end
        chk({7'h00, seen}, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped address
        rd(amsc_pkg::ADDR_DELTA_CFG, 8'h00);
        rd(amsc_pkg::ADDR_PERIOD_CFG, 8'h00);
        rd(amsc_pkg::ADDR_BATT_THRESH, 8'h00);
        rd(amsc_pkg::ADDR_START_MEAS, 8'h00);
        rd(8'h00, 8'h00);
        // Three single requests at once, reserved go bits set too
        wr(amsc_pkg::ADDR_BATT_THRESH, 8'h80);
        wr(amsc_pkg::ADDR_START_MEAS, 8'h7F);
        conv(2'h2, 8'h55, 8'h01);
        conv(2'h1, 8'h40, 8'h01);
        conv(2'h0, 8'h7F, 8'h01);
        chk({7'h00, low_battery_flag}, 8'h01);
        rd(amsc_pkg::ADDR_START_MEAS, 8'h00);
        rd(amsc_pkg::ADDR_SUPPLY_RESULT, 8'h55);
        rd(amsc_pkg::ADDR_TEMP_RESULT, 8'h40);
        rd(amsc_pkg::ADDR_BATT_RESULT, 8'h7F);
        @(posedge ref_clk) low_battery_clear <= 1'b1;
        @(posedge ref_clk) low_battery_clear <= 1'b0;
        // Battery at the threshold is not low, but a single request still interrupts
        wr(amsc_pkg::ADDR_START_MEAS, 8'h01);
        conv(2'h0, 8'h80, 8'h01);
        chk({7'h00, low_battery_flag}, 8'h00);
        // Lock-loss fault and its acknowledge
        @(posedge ref_clk) lock_loss_cause <= 1'b1;
        @(posedge ref_clk) lock_loss_cause <= 1'b0;
        #1 chk({7'h00, lock_loss_fault}, 8'h01);
        wr(amsc_pkg::ADDR_START_MEAS, 8'h80);
        #1 chk({7'h00, lock_loss_fault}, 8'h00);
        rd(amsc_pkg::ADDR_START_MEAS, 8'h00);
        // Background temperature every minute, change threshold of 2
        wr(amsc_pkg::ADDR_DELTA_CFG, 8'h10);
        wr(amsc_pkg::ADDR_PERIOD_CFG, 8'h03);
        tick();
        no_req(10);
        clock_calendar_enable <= 1'b1;
        tick();
        conv(2'h1, 8'h42, 8'h00);
        rd(amsc_pkg::ADDR_TEMP_RESULT, 8'h40);
        tick();
        conv(2'h1, 8'h3D, 8'h01);
        rd(amsc_pkg::ADDR_TEMP_RESULT, 8'h3D);
        wr(amsc_pkg::ADDR_DELTA_CFG, 8'h38);
        sleep_power_state <= 1'b1;
        tick();
        no_req(10);
        lowpower_keep <= 3'h2;
        tick();
        conv(2'h1, 8'h3D, 8'h01);
        sleep_power_state <= 1'b0;
        // Battery-powered state without keep-alive holds background work back
        battery_power_state <= 1'b1;
        lowpower_keep <= 3'h0;
        tick();
        no_req(10);
        battery_power_state <= 1'b0;
        wr(amsc_pkg::ADDR_DELTA_CFG, 8'h00);
        tick();
        conv(2'h1, 8'h99, 8'h00);
        // Supply every two minutes, interrupt on every conversion
        wr(amsc_pkg::ADDR_DELTA_CFG, 8'h07);
        wr(amsc_pkg::ADDR_PERIOD_CFG, 8'h20);
        tick();
        // Rewriting the period mid-interval must start counting afresh
        wr(amsc_pkg::ADDR_PERIOD_CFG, 8'h20);
        tick();
        no_req(10);
        tick();
        conv(2'h2, 8'h55, 8'h01);
        // Supply threshold 000: background result neither interrupts nor loads
        wr(amsc_pkg::ADDR_DELTA_CFG, 8'h00);
        tick();
        tick();
        conv(2'h2, 8'h77, 8'h00);
        rd(amsc_pkg::ADDR_SUPPLY_RESULT, 8'h55);
        // Battery every sixteen minutes, low reading flagged
        wr(amsc_pkg::ADDR_PERIOD_CFG, 8'h04);
        repeat (15) tick();
        no_req(10);
        tick();
        conv(2'h0, 8'h10, 8'h01);
        chk({7'h00, low_battery_flag}, 8'h01);
        give_verdict();
    end
endmodule // amsc_scheduler_tb
`default_nettype wire
